// ### rtl/dram_command_timing_enforcer.sv
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
module dram_command_timing_enforcer
   import dram_timing_pkg::*;
#(
   parameter logic [7:0] MAW_ACT_MAX = 8'h10
)(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [15:0] wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        upd_valid_i,
   input  wire logic [4:0]  upd_idx_i,
   input  wire logic [31:0] upd_data_i,
   input  wire logic        cmd_valid_i,
   input  wire cmd_t        cmd_i,
   output logic             cmd_ready_o,
   output cmd_t             iss_o,
   output logic             iss_valid_o
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
      return (v == '0) ? '0 : v - 1'b1;
   endfunction : dec

   function automatic logic [CW-1:0] mx(input logic [CW-1:0] a,
                                        input logic [CW-1:0] b);
      return (a > b) ? a : b;
   endfunction : mx

   function automatic logic [CW-1:0] f8(input logic [31:0] w,
                                        input int lsb);
      return dec({2'b00, w[lsb +: FW]});
   endfunction : f8

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [31:0]   snap_r    [NSNAP];
   logic [31:0]   snap_nxt  [NSNAP];
   ctl_state_t    state_r;
   ctl_state_t    state_nxt;
   logic          ack_r;
   logic [31:0]   dat_r;
   logic [31:0]   dat_nxt;
   logic [CW-1:0] rk_any_r  [NRANK];
   logic [CW-1:0] rk_any_nxt[NRANK];
   logic [CW-1:0] rk_pd_r   [NRANK];
   logic [CW-1:0] rk_pd_nxt [NRANK];
   logic [CW-1:0] rrd_l_r   [NRANK];
   logic [CW-1:0] rrd_l_nxt [NRANK];
   logic [CW-1:0] rrd_s_r   [NRANK];
   logic [CW-1:0] rrd_s_nxt [NRANK];
   logic [CW-1:0] maw_r     [NRANK];
   logic [CW-1:0] maw_nxt   [NRANK];
   logic [7:0]    mawn_r    [NRANK];
   logic [7:0]    mawn_nxt  [NRANK];
   logic [1:0]    lact_r    [NRANK];
   logic [1:0]    lact_nxt  [NRANK];
   logic [CW-1:0] faw_r     [NRANK][4];
   logic [CW-1:0] faw_nxt   [NRANK][4];
   logic [CW-1:0] bk_col_r  [NBANK];
   logic [CW-1:0] bk_col_nxt[NBANK];
   logic [CW-1:0] bk_pre_r  [NBANK];
   logic [CW-1:0] bk_pre_nxt[NBANK];
   logic [CW-1:0] bk_any_r  [NBANK];
   logic [CW-1:0] bk_any_nxt[NBANK];
   logic [CW-1:0] bk_nw_r   [NBANK];
   logic [CW-1:0] bk_nw_nxt [NBANK];
   // Pair 0 rd-rd, 1 rd-wr, 2 wr-rd, 3 wr-wr; class 0 s, 1 l, 2 cs
   logic [CW-1:0] gap_r     [4][3];
   logic [CW-1:0] gap_nxt   [4][3];
   logic          lrd_rk_r, lrd_rk_nxt, lwr_rk_r, lwr_rk_nxt;
   logic [1:0]    lrd_bg_r, lrd_bg_nxt, lwr_bg_r, lwr_bg_nxt;
   cmd_t          iss_r;
   logic          iss_v_r;

   // ------------------------------------------------------------
   // Register bus decode
   // ------------------------------------------------------------
   wire        wb_req   = wb_cyc_i & wb_stb_i & ~ack_r;
   wire        ctrl_hit = (wb_adr_i == CTRL_OFS);
   wire        stat_hit = (wb_adr_i == STAT_OFS);
   wire        ctrl_wr  = wb_req & wb_we_i & ctrl_hit & wb_sel_i[0];
   wire [4:0]  upd_lim  = 5'(NSNAP);
   logic       upd_ok;
   logic       cmd_en;
   logic [31:0] snap_rd;
   logic [NRANK-1:0] rk_busy;

   always_comb begin
      case (state_r)
         ST_READY:  upd_ok = 1'b0;
         ST_CONFIG: upd_ok = 1'b1;
         ST_LOWPWR: upd_ok = 1'b1;
         ST_PAUSED: upd_ok = 1'b1;
         default:   upd_ok = 1'b0;
      endcase
   end

   // Commands are frozen in config and paused; low-power issues them while timings may change
   assign cmd_en = (state_r == ST_READY) | (state_r == ST_LOWPWR);

   always_comb begin
      snap_rd = 32'h00000000;
      for (int i = 0; i < NSNAP; i++) begin
         if (wb_adr_i == SNAP_OFS[i]) begin
            snap_rd = snap_r[i];
         end
      end
   end

   always_comb begin
      for (int r = 0; r < NRANK; r++) begin
         rk_busy[r] = (rk_any_r[r] != '0);
      end
   end

   assign state_nxt = ctrl_wr ? ctl_state_t'(wb_dat_i[1:0]) : state_r;
   assign dat_nxt = ctrl_hit ? {30'h0, state_r} :
                    stat_hit ? {30'h0, rk_busy} : snap_rd;

   // Writes to snapshot offsets are acked and dropped
   always_comb begin
      for (int i = 0; i < NSNAP; i++) begin
         snap_nxt[i] = snap_r[i];
      end
      if (upd_valid_i && upd_ok && (upd_idx_i < upd_lim)) begin
         snap_nxt[upd_idx_i] = upd_data_i;
      end
   end

   // ------------------------------------------------------------
   // Legality
   // ------------------------------------------------------------
   wire        rk  = cmd_i.rank;
   wire [4:0]  bi  = {cmd_i.rank, cmd_i.bg, cmd_i.bank};
   wire [1:0]  crd = (rk != lrd_rk_r) ? 2'h2 :
                     (cmd_i.bg == lrd_bg_r) ? 2'h1 : 2'h0;
   wire [1:0]  cwr = (rk != lwr_rk_r) ? 2'h2 :
                     (cmd_i.bg == lwr_bg_r) ? 2'h1 : 2'h0;
   wire rank_ok = (rk_any_r[rk] == '0);
   wire bk_free = (bk_any_r[bi] == '0);
   wire bk_nw   = (bk_nw_r[bi] == '0);
   wire col_ok  = (bk_col_r[bi] == '0);
   wire pre_ok  = (bk_pre_r[bi] == '0);
   wire rd_gap  = (gap_r[0][crd] == '0) & (gap_r[2][cwr] == '0);
   wire wr_gap  = (gap_r[1][crd] == '0) & (gap_r[3][cwr] == '0);
   wire rrd_ok  = (cmd_i.bg == lact_r[rk]) ? (rrd_l_r[rk] == '0)
                                           : (rrd_s_r[rk] == '0);
   wire maw_ok  = (maw_r[rk] == '0) | (mawn_r[rk] < MAW_ACT_MAX);
   logic faw_ok;
   logic [1:0] faw_slot;
   logic rank_idle;
   logic kind_ok;

   always_comb begin
      faw_ok   = 1'b0;
      faw_slot = 2'h0;
      for (int s = 3; s >= 0; s--) begin
         if (faw_r[rk][s] == '0) begin
            faw_ok   = 1'b1;
            faw_slot = 2'(s);
         end
      end
   end

   always_comb begin
      rank_idle = 1'b1;
      for (int b = 0; b < NBANK / NRANK; b++) begin
         if (bk_pre_r[{rk, 4'(b)}] != '0 ||
             bk_nw_r[{rk, 4'(b)}] != '0 ||
             bk_any_r[{rk, 4'(b)}] != '0) begin
            rank_idle = 1'b0;
         end
      end
   end

   always_comb begin
      case (cmd_i.kind)
         CK_MRR:  kind_ok = 1'b1;
         CK_MRW:  kind_ok = 1'b1;
         CK_ACT:  kind_ok = bk_free & bk_nw & rrd_ok & faw_ok & maw_ok;
         CK_PRE:  kind_ok = bk_free & bk_nw & pre_ok;
         CK_PREA: kind_ok = rank_idle;
         CK_RD:   kind_ok = bk_free & bk_nw & col_ok & rd_gap;
         CK_WR:   kind_ok = bk_free & col_ok & wr_gap;
         CK_PDE:  kind_ok = (rk_pd_r[rk] == '0);
         CK_MPDX: kind_ok = 1'b1;
         default: kind_ok = 1'b0;
      endcase
   end

   assign cmd_ready_o = cmd_en & rank_ok & kind_ok;
   wire fire = cmd_valid_i & cmd_ready_o;

   // ------------------------------------------------------------
   // Counter next values
   // ------------------------------------------------------------
   always_comb begin
      for (int r = 0; r < NRANK; r++) begin
         rk_any_nxt[r] = dec(rk_any_r[r]);
         rk_pd_nxt[r]  = dec(rk_pd_r[r]);
         rrd_l_nxt[r]  = dec(rrd_l_r[r]);
         rrd_s_nxt[r]  = dec(rrd_s_r[r]);
         maw_nxt[r]    = dec(maw_r[r]);
         mawn_nxt[r]   = mawn_r[r];
         lact_nxt[r]   = lact_r[r];
         for (int s = 0; s < 4; s++) begin
            faw_nxt[r][s] = dec(faw_r[r][s]);
         end
      end
      for (int b = 0; b < NBANK; b++) begin
         bk_col_nxt[b] = dec(bk_col_r[b]);
         bk_pre_nxt[b] = dec(bk_pre_r[b]);
         bk_any_nxt[b] = dec(bk_any_r[b]);
         bk_nw_nxt[b]  = dec(bk_nw_r[b]);
      end
      for (int p = 0; p < 4; p++) begin
         for (int k = 0; k < 3; k++) begin
            gap_nxt[p][k] = dec(gap_r[p][k]);
         end
      end
      lrd_rk_nxt = lrd_rk_r;
      lrd_bg_nxt = lrd_bg_r;
      lwr_rk_nxt = lwr_rk_r;
      lwr_bg_nxt = lwr_bg_r;
      if (fire) begin
         case (cmd_i.kind)
            CK_MRR: rk_any_nxt[rk] = mx(rk_any_nxt[rk],
                                        f8(snap_r[SN_MRR], 0));
            CK_MRW: rk_any_nxt[rk] = mx(rk_any_nxt[rk],
                                        f8(snap_r[SN_MRW], 0));
            CK_PREA: rk_any_nxt[rk] = mx(rk_any_nxt[rk],
                                         f8(snap_r[SN_PALL], 0));
            CK_PDE: rk_any_nxt[rk] = mx(rk_any_nxt[rk],
                                        f8(snap_r[SN_EP], 0));
            CK_MPDX: rk_any_nxt[rk] = mx(rk_any_nxt[rk],
                                         dec(snap_r[SN_XMPD][CW-1:0]));
            CK_PRE: bk_any_nxt[bi] = mx(bk_any_nxt[bi],
                                        f8(snap_r[SN_PREC], 0));
            CK_ACT: begin
               bk_col_nxt[bi] = mx(bk_col_nxt[bi],
                                   f8(snap_r[SN_RCOL], 0));
               bk_pre_nxt[bi] = mx(bk_pre_nxt[bi],
                                   f8(snap_r[SN_RACT], 0));
               rrd_l_nxt[rk] = f8(snap_r[SN_ASPC], F_L);
               rrd_s_nxt[rk] = f8(snap_r[SN_ASPC], F_S);
               lact_nxt[rk]  = cmd_i.bg;
               faw_nxt[rk][faw_slot] = f8(snap_r[SN_AWIN], F_FAW);
               if (maw_r[rk] == '0) begin
                  maw_nxt[rk]  = dec(snap_r[SN_AWIN][F_MAW +: CW]);
                  mawn_nxt[rk] = 8'h01;
               end else begin
                  mawn_nxt[rk] = mawn_r[rk] + 8'h01;
               end
            end
            CK_RD: begin
               rk_pd_nxt[rk] = mx(rk_pd_nxt[rk],
                                  f8(snap_r[SN_RDPD], 0));
               bk_pre_nxt[bi] = mx(bk_pre_nxt[bi],
                                   f8(snap_r[SN_RTP], 0));
               gap_nxt[0][0] = f8(snap_r[SN_RTR], F_S);
               gap_nxt[0][1] = f8(snap_r[SN_RTR], F_L);
               gap_nxt[0][2] = f8(snap_r[SN_RTR], F_CS);
               gap_nxt[1][0] = f8(snap_r[SN_RTW], F_S);
               gap_nxt[1][1] = f8(snap_r[SN_RTW], F_L);
               gap_nxt[1][2] = f8(snap_r[SN_RTW], F_CS);
               lrd_rk_nxt = rk;
               lrd_bg_nxt = cmd_i.bg;
            end
            CK_WR: begin
               bk_nw_nxt[bi] = mx(bk_nw_nxt[bi],
                                  f8(snap_r[SN_WREC], 0));
               gap_nxt[2][0] = f8(snap_r[SN_WTR], F_S);
               gap_nxt[2][1] = f8(snap_r[SN_WTR], F_L);
               gap_nxt[2][2] = f8(snap_r[SN_WTR], F_CS);
               gap_nxt[3][0] = f8(snap_r[SN_WTW], F_S);
               gap_nxt[3][1] = f8(snap_r[SN_WTW], F_L);
               gap_nxt[3][2] = f8(snap_r[SN_WTW], F_CS);
               lwr_rk_nxt = rk;
               lwr_bg_nxt = cmd_i.bg;
            end
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Flops
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         snap_r  <= SNAP_RST;
         state_r <= ST_CONFIG;
         ack_r   <= 1'b0;
         dat_r   <= 32'h00000000;
         iss_r   <= '0;
         iss_v_r <= 1'b0;
      end else begin
         snap_r  <= snap_nxt;
         state_r <= state_nxt;
         ack_r   <= wb_req;
         dat_r   <= dat_nxt;
         iss_r   <= cmd_i;
         iss_v_r <= fire;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rk_any_r <= '{default: '0};
         rk_pd_r  <= '{default: '0};
         rrd_l_r  <= '{default: '0};
         rrd_s_r  <= '{default: '0};
         maw_r    <= '{default: '0};
         mawn_r   <= '{default: '0};
         lact_r   <= '{default: '0};
         faw_r    <= '{default: '{default: '0}};
         bk_col_r <= '{default: '0};
         bk_pre_r <= '{default: '0};
         bk_any_r <= '{default: '0};
         bk_nw_r  <= '{default: '0};
         gap_r    <= '{default: '{default: '0}};
         lrd_rk_r <= 1'b0;
         lrd_bg_r <= 2'h0;
         lwr_rk_r <= 1'b0;
         lwr_bg_r <= 2'h0;
      end else begin
         rk_any_r <= rk_any_nxt;
         rk_pd_r  <= rk_pd_nxt;
         rrd_l_r  <= rrd_l_nxt;
         rrd_s_r  <= rrd_s_nxt;
         maw_r    <= maw_nxt;
         mawn_r   <= mawn_nxt;
         lact_r   <= lact_nxt;
         faw_r    <= faw_nxt;
         bk_col_r <= bk_col_nxt;
         bk_pre_r <= bk_pre_nxt;
         bk_any_r <= bk_any_nxt;
         bk_nw_r  <= bk_nw_nxt;
         gap_r    <= gap_nxt;
         lrd_rk_r <= lrd_rk_nxt;
         lrd_bg_r <= lrd_bg_nxt;
         lwr_rk_r <= lwr_rk_nxt;
         lwr_bg_r <= lwr_bg_nxt;
      end
   end

   assign wb_ack_o    = ack_r;
   assign wb_dat_o    = dat_r;
   assign iss_o       = iss_r;
   assign iss_valid_o = iss_v_r;

endmodule : dram_command_timing_enforcer

// ### rtl/dram_timing_pkg.sv
// Behaviour
// - Snapshots read anytime, ignore writes, update only in config/low-power/paused.
// - After mode register read, block the rank for the read delay.
// - After mode register write, block the rank for the write delay.
// - After a read, hold power-down entry to that rank for its delay.
// - After activate, hold reads and writes to that bank for row-to-column.
// - Hold precharge of a bank until minimum active time after activate.
// - After precharge, block the bank for the precharge recovery delay.
// - After precharge-all, block the rank for the all-bank recovery delay.
// - Space activates per rank: long gap same group, short gap other group.
// - Limit activates by four-activate window and maximum activate window.
// - Space reads by other-group, same-group or other-chip gap.
// - Space write after read by other-group, same-group or other-chip gap.
// - Hold precharge after read to the same bank for read-to-precharge.
// - After a write, non-write commands to that bank wait write recovery.
// - Space read after write by other-group, same-group or other-chip gap.
// - Space writes by other-group, same-group or other-chip gap.
// - After maximum power-down exit, block the rank for the exit delay.
// - After power-down entry, block the rank for the entry delay.
package dram_timing_pkg;
   localparam int NRANK = 2;
   localparam int NBANK = 32;
   localparam int NSNAP = 17;
   localparam int CW    = 10;
   localparam int FW    = 8;

   // ------------------------------------------------------------
   // Snapshot indices
   // ------------------------------------------------------------
   localparam int SN_MRR  = 0;
   localparam int SN_MRW  = 1;
   localparam int SN_RDPD = 2;
   localparam int SN_RCOL = 3;
   localparam int SN_RACT = 4;
   localparam int SN_PREC = 5;
   localparam int SN_PALL = 6;
   localparam int SN_ASPC = 7;
   localparam int SN_AWIN = 8;
   localparam int SN_RTR  = 9;
   localparam int SN_RTW  = 10;
   localparam int SN_RTP  = 11;
   localparam int SN_WREC = 12;
   localparam int SN_WTR  = 13;
   localparam int SN_WTW  = 14;
   localparam int SN_XMPD = 15;
   localparam int SN_EP   = 16;

   localparam logic [15:0] SNAP_OFS [NSNAP] = '{
      16'h1204, 16'h120C, 16'h1210, 16'h1218, 16'h121C, 16'h1220,
      16'h1224, 16'h1228, 16'h122C, 16'h1234, 16'h1238, 16'h123C,
      16'h1244, 16'h1248, 16'h124C, 16'h1254, 16'h1258};
   localparam logic [31:0] SNAP_RST [NSNAP] = '{
      32'h00008C23, 32'h00000002, 32'h0000000A, 32'h00000005,
      32'h0000000E, 32'h00000005, 32'h00000005, 32'h00000404,
      32'h03560014, 32'h00060404, 32'h00060606, 32'h00000004,
      32'h00000005, 32'h00040505, 32'h00060404, 32'h000003FF,
      32'h00000002};

   localparam logic [15:0] CTRL_OFS = 16'h1280;
   localparam logic [15:0] STAT_OFS = 16'h1284;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int F_S   = 0;
   localparam int F_L   = 8;
   localparam int F_CS  = 16;
   localparam int F_FAW = 0;
   localparam int F_MAW = 16;

   typedef enum logic [1:0] {
      ST_READY  = 2'b00,
      ST_CONFIG = 2'b01,
      ST_LOWPWR = 2'b10,
      ST_PAUSED = 2'b11
   } ctl_state_t;

   typedef enum logic [3:0] {
      CK_MRR  = 4'h0,
      CK_MRW  = 4'h1,
      CK_ACT  = 4'h2,
      CK_PRE  = 4'h3,
      CK_PREA = 4'h4,
      CK_RD   = 4'h5,
      CK_WR   = 4'h6,
      CK_PDE  = 4'h7,
      CK_MPDX = 4'h8
   } cmd_kind_t;

   typedef struct packed {
      cmd_kind_t  kind;
      logic       rank;
      logic [1:0] bg;
      logic [1:0] bank;
   } cmd_t;
endpackage : dram_timing_pkg

// ### testbench/dram_rank_model.sv
`timescale 1ns/1ps
module dram_rank_model
   import dram_timing_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       iss_valid_i,
   input  wire cmd_t       iss_i,
   output logic      [7:0] fault_cnt_o
);
   // ------------------------------------------------------------
   // Bank and power state of both ranks
   // ------------------------------------------------------------
   // Only state faults are counted; a real die corrupts silently
   logic [31:0] open_r;
   logic [1:0]  pd_r;
   wire  [4:0]  bi_w    = {iss_i.rank, iss_i.bg, iss_i.bank};
   wire         pd_bad  = pd_r[iss_i.rank] && iss_i.kind != CK_MPDX;
   wire         act_bad = iss_i.kind == CK_ACT && open_r[bi_w];
   wire         col_bad = iss_i.kind inside {CK_RD, CK_WR} && !open_r[bi_w];
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         open_r      <= 32'h00000000;
         pd_r        <= 2'h0;
         fault_cnt_o <= 8'h00;
      end else if (iss_valid_i) begin
         fault_cnt_o <= fault_cnt_o + {7'h00, pd_bad | act_bad | col_bad};
         case (iss_i.kind)
            CK_ACT:  open_r[bi_w] <= 1'b1;
            CK_PRE:  open_r[bi_w] <= 1'b0;
            CK_PREA: open_r[{iss_i.rank, 4'h0} +: 16] <= 16'h0000;
            CK_PDE:  pd_r[iss_i.rank] <= 1'b1;
            CK_MPDX: pd_r[iss_i.rank] <= 1'b0;
            default: ;
         endcase
      end
   end
endmodule : dram_rank_model

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
   import dram_timing_pkg::*;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [15:0] wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, upd_data_i, rd;
   logic        upd_valid_i, cmd_valid_i, cmd_ready_o, iss_valid_o;
   logic [4:0]  upd_idx_i;
   cmd_t        cmd_i, iss_o;
   logic [7:0]  fault_cnt;
   int          error_cnt, checked;
   longint      last_t;
   dram_command_timing_enforcer dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .upd_valid_i(upd_valid_i),
      .upd_idx_i(upd_idx_i), .upd_data_i(upd_data_i),
      .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
      .cmd_ready_o(cmd_ready_o), .iss_o(iss_o), .iss_valid_o(iss_valid_o));
   dram_rank_model ranks (.clk_i(clk_i), .rst_i(rst_i),
      .iss_valid_i(iss_valid_o), .iss_i(iss_o), .fault_cnt_o(fault_cnt));
   // ------------------------------------------------------------
   // Bus and command tasks
   // ------------------------------------------------------------
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic wb(input logic w, input logic [15:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1)
         error_cnt++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic rdc(input logic [15:0] a, input logic [31:0] e);
      logic [31:0] q;
      wb(1'b0, a, 32'h00000000, q);
      `CHK(q, e)
   endtask : rdc
   task automatic upd(input logic [4:0] i, input logic [31:0] d);
      @(posedge clk_i);
      upd_idx_i   <= i;
      upd_data_i  <= d;
      upd_valid_i <= 1'b1;
      @(posedge clk_i);
      upd_valid_i <= 1'b0;
   endtask : upd
   // Gap is counted from the previous fire, whatever came between
   task automatic st(input logic idl, input cmd_kind_t k,
                     input logic [4:0] b, input int g);
      int     n;
      longint t;
      if (idl) begin
         cmd_valid_i <= 1'b0;
         repeat (30) @(posedge clk_i);
      end
      cmd_i       <= {k, b};
      cmd_valid_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (cmd_ready_o !== 1'b1 && n < 1100);
      if (cmd_ready_o !== 1'b1)
         error_cnt++;
      t = $time / 40;
      if (g > 0)
         `CHK(32'(t - last_t), 32'(g))
      last_t = t;
   endtask : st
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   initial begin
      #200000;
      error_cnt++;
      wrap_up();
   end
   initial begin
      {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, upd_valid_i} = 5'h10;
      {wb_adr_i, wb_dat_i, upd_idx_i, upd_data_i} = '0;
      wb_sel_i    = 4'hF;
      cmd_valid_i = 1'b0;
      cmd_i       = '0;
      error_cnt   = 0;
      checked     = 0;
      last_t      = 0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < NSNAP; i++)
         rdc(SNAP_OFS[i], SNAP_RST[i]);
      wb(1'b1, SNAP_OFS[SN_PREC], 32'hFFFFFFFF, rd);
      rdc(SNAP_OFS[SN_PREC], 32'h00000005);
      rdc(16'h1300, 32'h00000000);
      upd(5'(SN_RCOL), 32'h00000007);
      rdc(SNAP_OFS[SN_RCOL], 32'h00000007);
      wb(1'b1, CTRL_OFS, 32'h00000000, rd);
      rdc(CTRL_OFS, 32'h00000000);
      upd(5'(SN_RCOL), 32'h00000002);
      rdc(SNAP_OFS[SN_RCOL], 32'h00000007);
      $display("Test registers done");
      st(1'b1, CK_ACT,  5'h10, 0);
      st(1'b1, CK_ACT,  5'h00, 0);
      st(1'b0, CK_ACT,  5'h04, 4);
      st(1'b0, CK_ACT,  5'h08, 4);
      st(1'b0, CK_ACT,  5'h0C, 4);
      st(1'b0, CK_ACT,  5'h01, 8);
      st(1'b0, CK_RD,   5'h01, 7);
      st(1'b1, CK_RD,   5'h00, 0);
      st(1'b0, CK_RD,   5'h10, 6);
      st(1'b0, CK_WR,   5'h10, 6);
      st(1'b0, CK_RD,   5'h00, 4);
      st(1'b1, CK_WR,   5'h00, 0);
      st(1'b0, CK_WR,   5'h10, 6);
      st(1'b0, CK_PRE,  5'h10, 5);
      st(1'b1, CK_RD,   5'h00, 0);
      st(1'b0, CK_PRE,  5'h00, 4);
      st(1'b0, CK_ACT,  5'h00, 5);
      st(1'b0, CK_PRE,  5'h00, 14);
      st(1'b1, CK_PREA, 5'h00, 0);
      st(1'b0, CK_ACT,  5'h04, 5);
      st(1'b1, CK_MRW,  5'h00, 0);
      st(1'b0, CK_ACT,  5'h05, 2);
      st(1'b1, CK_MRR,  5'h10, 0);
      st(1'b0, CK_ACT,  5'h11, 35);
      st(1'b0, CK_RD,   5'h11, 7);
      st(1'b0, CK_PDE,  5'h10, 10);
      st(1'b0, CK_MPDX, 5'h10, 2);
      cmd_valid_i <= 1'b0;
      rdc(STAT_OFS, 32'h00000002);
      st(1'b0, CK_RD,   5'h11, 1023);
      $display("Test command gaps done");
      cmd_valid_i <= 1'b0;
      wb(1'b1, CTRL_OFS, 32'h00000001, rd);
      @(posedge clk_i);
      cmd_i <= {CK_ACT, 5'h0E};
      @(negedge clk_i);
      `CHK(cmd_ready_o, 1'b0)
      wb(1'b1, CTRL_OFS, 32'h00000002, rd);
      @(negedge clk_i);
      `CHK(cmd_ready_o, 1'b1)
      upd(5'(SN_RCOL), 32'h00000009);
      rdc(SNAP_OFS[SN_RCOL], 32'h00000009);
      `CHK(fault_cnt, 8'h00)
      $display("Test state gating done");
      wrap_up();
   end
endmodule : tb_top

// ### testbench/timing_checker_assertions.sv
`timescale 1ns/1ps
module timing_checker
   import dram_timing_pkg::*;
#(
   parameter logic [7:0] MAW_ACT_MAX = 8'h10
)(
   input logic        clk_i,
   input logic        rst_i,
   input logic        wb_cyc_i,
   input logic        wb_stb_i,
   input logic        wb_we_i,
   input logic [15:0] wb_adr_i,
   input logic [3:0]  wb_sel_i,
   input logic [31:0] wb_dat_i,
   input logic [31:0] wb_dat_o,
   input logic        wb_ack_o,
   input logic        upd_valid_i,
   input logic [4:0]  upd_idx_i,
   input logic [31:0] upd_data_i,
   input logic        cmd_valid_i,
   input cmd_t        cmd_i,
   input logic        cmd_ready_o,
   input cmd_t        iss_o,
   input logic        iss_valid_o
);
   // ------------------------------------------------------------
   // Shadow of state and snapshots, cycles since each command
   // ------------------------------------------------------------
   logic [1:0]  st_r;
   logic [31:0] sh_r    [NSNAP];
   logic [10:0] since_r [9];
   logic [4:0]  lb_r    [9];
   logic [31:0] exp_w;
   logic        hit_w;
   wire         take_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire         fire_w = cmd_valid_i & cmd_ready_o;
   wire  [4:0]  cb_w   = {cmd_i.rank, cmd_i.bg, cmd_i.bank};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= 2'h1;
         sh_r <= SNAP_RST;
      end else begin
         if (take_w && wb_we_i && wb_adr_i == CTRL_OFS && wb_sel_i[0])
            st_r <= wb_dat_i[1:0];
         if (upd_valid_i && st_r != 2'h0 && upd_idx_i < 5'h11)
            sh_r[upd_idx_i] <= upd_data_i;
      end
   end
   // Saturating, so a long idle never wraps into a short gap
   always_ff @(posedge clk_i) begin
      for (int k = 0; k < 9; k++) begin
         if (rst_i) begin
            since_r[k] <= 11'h7FF;
            lb_r[k]    <= 5'h00;
         end else if (fire_w && cmd_i.kind == 4'(k)) begin
            since_r[k] <= 11'h001;
            lb_r[k]    <= cb_w;
         end else if (since_r[k] != 11'h7FF) begin
            since_r[k] <= since_r[k] + 11'h001;
         end
      end
   end
   always_comb begin
      hit_w = 1'b0;
      exp_w = 32'h00000000;
      for (int i = 0; i < NSNAP; i++) begin
         if (wb_adr_i == SNAP_OFS[i]) begin
            hit_w = 1'b1;
            exp_w = sh_r[i];
         end
      end
   end
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack;
      take_w |=> wb_ack_o ##1 !wb_ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("bus ack shape");
   property p_snap;
      take_w && !wb_we_i && hit_w && !upd_valid_i
         |=> wb_dat_o == $past(exp_w);
   endproperty
   a_snap: assert property (p_snap) else $error("snapshot data");
   property p_iss;
      fire_w |=> iss_valid_o && iss_o == $past(cmd_i);
   endproperty
   a_iss: assert property (p_iss) else $error("issue missing");
   property p_rcd;
      fire_w && cmd_i.kind inside {CK_RD, CK_WR} && cb_w == lb_r[CK_ACT]
         |-> since_r[CK_ACT] >= {3'h0, sh_r[SN_RCOL][7:0]};
   endproperty
   a_rcd: assert property (p_rcd) else $error("rcd short");
   property p_ras;
      fire_w && cmd_i.kind == CK_PRE && cb_w == lb_r[CK_ACT]
         |-> since_r[CK_ACT] >= {3'h0, sh_r[SN_RACT][7:0]};
   endproperty
   a_ras: assert property (p_ras) else $error("ras short");
   property p_rp;
      fire_w && cmd_i.kind inside {CK_ACT, CK_RD, CK_WR}
         && cb_w == lb_r[CK_PRE]
         |-> since_r[CK_PRE] >= {3'h0, sh_r[SN_PREC][7:0]};
   endproperty
   a_rp: assert property (p_rp) else $error("rp short");
   property p_mrw;
      fire_w && cb_w[4] == lb_r[CK_MRW][4]
         |-> since_r[CK_MRW] >= {3'h0, sh_r[SN_MRW][7:0]};
   endproperty
   a_mrw: assert property (p_mrw) else $error("mrw short");
   property p_xmpd;
      fire_w && cb_w[4] == lb_r[CK_MPDX][4]
         |-> since_r[CK_MPDX] >= {1'h0, sh_r[SN_XMPD][9:0]};
   endproperty
   a_xmpd: assert property (p_xmpd) else $error("exit short");
   c_act: cover property (fire_w && cmd_i.kind == CK_ACT);
   c_mpdx: cover property (fire_w && cmd_i.kind == CK_MPDX);
   c_rd: cover property (take_w && !wb_we_i && hit_w);
endmodule : timing_checker

bind dram_command_timing_enforcer timing_checker #(
   .MAW_ACT_MAX(MAW_ACT_MAX)
) chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .upd_valid_i(upd_valid_i),
   .upd_idx_i(upd_idx_i), .upd_data_i(upd_data_i),
   .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
   .cmd_ready_o(cmd_ready_o), .iss_o(iss_o), .iss_valid_o(iss_valid_o)
);
